/* File: rvp_defs.svh */
// constants for reset and interrupt vector placement
`ifndef RVP_DEFS_SVH
`define RVP_DEFS_SVH

`define RVP_ADDR_W        12
`define RVP_NUM_W         5
`define RVP_N_SRC         18
`define RVP_RESET_ADDR    12'h000
`define RVP_APP_BASE      12'h000
`define RVP_FUSE_UNPROG   1'b1
`define RVP_CE_WINDOW     3'h4
`define RVP_FIRST_NUM     5'h02

`define RVP_ADDR_EXT0     12'h001
`define RVP_ADDR_EXT1     12'h002
`define RVP_ADDR_T2_COMP  12'h003
`define RVP_ADDR_T2_OVF   12'h004
`define RVP_ADDR_T1_CAPT  12'h005
`define RVP_ADDR_T1_COMPA 12'h006
`define RVP_ADDR_T1_COMPB 12'h007
`define RVP_ADDR_T1_OVF   12'h008
`define RVP_ADDR_T0_OVF   12'h009
`define RVP_ADDR_SPI      12'h00A
`define RVP_ADDR_RXC      12'h00B
`define RVP_ADDR_UDRE     12'h00C
`define RVP_ADDR_TXC      12'h00D
`define RVP_ADDR_CONV     12'h00E
`define RVP_ADDR_EEPROM   12'h00F
`define RVP_ADDR_COMP     12'h010
`define RVP_ADDR_TWO_WIRE 12'h011
`define RVP_ADDR_SPM      12'h012

`endif

/* File: rvp_pkg.sv */
// types shared by the vector placement block
`include "rvp_defs.svh"
package rvp_pkg;

    typedef enum logic [1:0] {
        RVP_ST_CAPTURE,
        RVP_ST_RESET_FETCH,
        RVP_ST_RUN,
        RVP_ST_IRQ_WAIT
    } rvp_phase_t;

    typedef struct packed {
        logic en;
        logic sel;
        logic ce;
    } rvp_ctl_wr_t;

    typedef struct packed {
        rvp_phase_t              phase;
        logic [`RVP_ADDR_W-1:0]  boot_base;
        logic [`RVP_ADDR_W-1:0]  reset_addr;
        logic                    reset_fetch;
        logic                    vsel;
        logic                    ce;
        logic [2:0]              ce_cnt;
        logic                    hold;
        logic                    blocked;
        logic                    irq_req;
        logic [`RVP_NUM_W-1:0]   irq_num;
        logic [`RVP_ADDR_W-1:0]  irq_addr;
    } rvp_state_t;

endpackage

/* File: rvp_irq_pick.sv */
// fixed-priority pick of the lowest pending interrupt source
`timescale 1ns/1ps
`include "rvp_defs.svh"
module rvp_irq_pick
    import rvp_pkg::*;
#(
    parameter int N_SRC = `RVP_N_SRC
) (
    // pending requests, bit 0 is the highest priority
    input  wire logic [N_SRC-1:0]       pending,
    // pick result
    output logic                        any,
    output logic [`RVP_NUM_W-1:0]       num,
    output logic [`RVP_ADDR_W-1:0]      tbl_addr
);

    function automatic logic [`RVP_ADDR_W-1:0] table_addr(
        input logic [`RVP_NUM_W-1:0] vnum
    );
        logic [`RVP_ADDR_W-1:0] a;
        a = `RVP_RESET_ADDR;
        unique case (vnum)
            5'h02: a = `RVP_ADDR_EXT0;
            5'h03: a = `RVP_ADDR_EXT1;
            5'h04: a = `RVP_ADDR_T2_COMP;
            5'h05: a = `RVP_ADDR_T2_OVF;
            5'h06: a = `RVP_ADDR_T1_CAPT;
            5'h07: a = `RVP_ADDR_T1_COMPA;
            5'h08: a = `RVP_ADDR_T1_COMPB;
            5'h09: a = `RVP_ADDR_T1_OVF;
            5'h0A: a = `RVP_ADDR_T0_OVF;
            5'h0B: a = `RVP_ADDR_SPI;
            5'h0C: a = `RVP_ADDR_RXC;
            5'h0D: a = `RVP_ADDR_UDRE;
            5'h0E: a = `RVP_ADDR_TXC;
            5'h0F: a = `RVP_ADDR_CONV;
            5'h10: a = `RVP_ADDR_EEPROM;
            5'h11: a = `RVP_ADDR_COMP;
            5'h12: a = `RVP_ADDR_TWO_WIRE;
            5'h13: a = `RVP_ADDR_SPM;
            default: a = `RVP_RESET_ADDR;
        endcase
        return a;
    endfunction

    always_comb begin
        any = 1'b0;
        num = `RVP_FIRST_NUM;
        // scan downward so the lowest index wins
        for (int i = N_SRC - 1; i >= 0; i--) begin
            if (pending[i]) begin
                any = 1'b1;
                num = `RVP_FIRST_NUM + `RVP_NUM_W'(i);
            end
        end
        tbl_addr = table_addr(num);
    end

endmodule

/* File: rvp_vector_ctl.sv */
// reset and interrupt vector address generation with table relocation
`timescale 1ns/1ps
`include "rvp_defs.svh"
module rvp_vector_ctl
    import rvp_pkg::*;
#(
    parameter int         N_SRC     = `RVP_N_SRC,
    parameter logic [2:0] CE_WINDOW = `RVP_CE_WINDOW
) (
    // clock and reset
    input  wire logic                    clk_sys,
    input  wire logic                    rstn,
    // fuse and boot section straps, caught after reset release
    input  wire logic                    boot_reset_select_fuse,
    input  wire logic [`RVP_ADDR_W-1:0]  boot_start_addr,
    // interrupt sources and global enable from the core
    input  wire logic [N_SRC-1:0]        irq_pending,
    input  wire logic                    global_irq_enable,
    // core vector fetch handshake
    input  wire logic                    irq_ack,
    output logic                         reset_fetch,
    output logic [`RVP_ADDR_W-1:0]       reset_addr,
    output logic                         irq_req,
    output logic [`RVP_NUM_W-1:0]        irq_vec_num,
    output logic [`RVP_ADDR_W-1:0]       irq_vec_addr,
    // general_irq_control write from the core
    input  wire rvp_ctl_wr_t             general_irq_control,
    // control state
    output logic                         vector_table_select,
    output logic                         vector_change_enable,
    output logic                         irq_blocked
);

    rvp_state_t              state_q;
    rvp_state_t              state_d;
    logic                    pick_any;
    logic [`RVP_NUM_W-1:0]   pick_num;
    logic [`RVP_ADDR_W-1:0]  pick_tbl;
    logic [`RVP_ADDR_W-1:0]  table_base;
    logic                    ce_arm;
    logic                    sel_write;
    logic                    block_now;

    rvp_irq_pick #(
        .N_SRC    (N_SRC)
    ) u_pick (
        .pending  (irq_pending),
        .any      (pick_any),
        .num      (pick_num),
        .tbl_addr (pick_tbl)
    );

    // a write that arms the change window and one that commits the select
    assign ce_arm    = general_irq_control.en & general_irq_control.ce;
    assign sel_write = general_irq_control.en & ~general_irq_control.ce
                       & state_q.ce;

    // blocking starts in the very cycle the arm write lands
    assign block_now = ce_arm | state_q.ce | state_q.hold;

    // relocated table sits at the boot section start
    assign table_base = state_q.vsel ? state_q.boot_base
                                     : `RVP_APP_BASE;

    always_comb begin
        state_d             = state_q;
        state_d.reset_fetch = 1'b0;
        state_d.hold        = 1'b0;

        unique case (state_q.phase)
            RVP_ST_CAPTURE: begin
                // straps are caught here, never under the async reset
                state_d.boot_base = boot_start_addr;
                if (boot_reset_select_fuse == `RVP_FUSE_UNPROG) begin
                    state_d.reset_addr = `RVP_RESET_ADDR;
                end else begin
                    state_d.reset_addr = boot_start_addr;
                end
                state_d.phase = RVP_ST_RESET_FETCH;
            end
            RVP_ST_RESET_FETCH: begin
                state_d.reset_fetch = 1'b1;
                state_d.phase       = RVP_ST_RUN;
            end
            RVP_ST_RUN: begin
                if (pick_any && global_irq_enable && !block_now) begin
                    state_d.irq_req  = 1'b1;
                    state_d.irq_num  = pick_num;
                    // base plus table slot, one word per vector
                    state_d.irq_addr = table_base + pick_tbl;
                    state_d.phase    = RVP_ST_IRQ_WAIT;
                end
            end
            RVP_ST_IRQ_WAIT: begin
                // vector stays stable until the core takes it
                if (irq_ack) begin
                    state_d.irq_req = 1'b0;
                    state_d.phase   = RVP_ST_RUN;
                end
            end
        endcase

        // change window times out after CE_WINDOW cycles
        if (state_q.ce) begin
            state_d.ce_cnt = state_q.ce_cnt - 3'h1;
            if (state_q.ce_cnt == 3'h1) begin
                state_d.ce = 1'b0;
            end
        end

        if (ce_arm) begin
            // re-arming restarts the window rather than committing
            state_d.ce     = 1'b1;
            state_d.ce_cnt = CE_WINDOW;
        end else if (sel_write) begin
            // a select write outside the window is ignored
            state_d.vsel   = general_irq_control.sel;
            state_d.ce     = 1'b0;
            state_d.ce_cnt = 3'h0;
            // keep blocking through the instruction after the write
            state_d.hold   = 1'b1;
        end

        state_d.blocked = state_d.ce | state_d.hold;
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_q.phase       <= RVP_ST_CAPTURE;
            state_q.boot_base   <= `RVP_APP_BASE;
            state_q.reset_addr  <= `RVP_RESET_ADDR;
            state_q.reset_fetch <= 1'b0;
            state_q.vsel        <= 1'b0;
            state_q.ce          <= 1'b0;
            state_q.ce_cnt      <= 3'h0;
            state_q.hold        <= 1'b0;
            state_q.blocked     <= 1'b0;
            state_q.irq_req     <= 1'b0;
            state_q.irq_num     <= `RVP_FIRST_NUM;
            state_q.irq_addr    <= `RVP_RESET_ADDR;
        end else begin
            state_q <= state_d;
        end
    end

    // every output is a field of the registered state
    assign reset_fetch          = state_q.reset_fetch;
    assign reset_addr           = state_q.reset_addr;
    assign irq_req              = state_q.irq_req;
    assign irq_vec_num          = state_q.irq_num;
    assign irq_vec_addr         = state_q.irq_addr;
    assign vector_table_select  = state_q.vsel;
    assign vector_change_enable = state_q.ce;
    assign irq_blocked          = state_q.blocked;

endmodule

/* File: rvp_vector_ctl_assertions.sv */
// concurrent checks on the vector placement block ports
`timescale 1ns/1ps
`include "rvp_defs.svh"
module rvp_vector_ctl_assertions
    import rvp_pkg::*;
#(
    parameter logic [2:0] CE_WINDOW = `RVP_CE_WINDOW
) (
    // clock, reset and straps
    input wire logic                   clk_sys,
    input wire logic                   rstn,
    input wire logic                   boot_reset_select_fuse,
    input wire logic [`RVP_ADDR_W-1:0] boot_start_addr,
    // core side
    input wire logic                   global_irq_enable,
    input wire logic                   irq_ack,
    input wire rvp_ctl_wr_t            general_irq_control,
    input wire logic                   reset_fetch,
    input wire logic [`RVP_ADDR_W-1:0] reset_addr,
    input wire logic                   irq_req,
    input wire logic [`RVP_NUM_W-1:0]  irq_vec_num,
    input wire logic [`RVP_ADDR_W-1:0] irq_vec_addr,
    input wire logic                   vector_table_select,
    input wire logic                   vector_change_enable,
    input wire logic                   irq_blocked
);
    // straps are held steady by the bench, so the live input stands in
    logic [`RVP_ADDR_W-1:0] base_w;
    logic                   arm_w;
    logic                   put_w;
    assign base_w = vector_table_select ? boot_start_addr : `RVP_APP_BASE;
    assign arm_w = general_irq_control.en && general_irq_control.ce;
    assign put_w = general_irq_control.en && !general_irq_control.ce;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    rst_addr_a: assert property (reset_fetch |-> reset_addr ==
        (boot_reset_select_fuse ? `RVP_RESET_ADDR : boot_start_addr))
        else $error("reset address wrong");
    fetch_pulse_a: assert property (reset_fetch |=> !reset_fetch)
        else $error("reset fetch longer than one cycle");
    vec_addr_a: assert property ($rose(irq_req) |->
        irq_vec_addr == base_w + 12'(irq_vec_num) - 12'h001)
        else $error("vector address wrong");
    vec_num_a: assert property ($rose(irq_req) |-> irq_vec_num >= 5'h02
        && irq_vec_num <= 5'h13 && $past(global_irq_enable))
        else $error("vector number or enable wrong");
    req_stand_a: assert property (irq_req && !irq_ack |=> irq_req
        && $stable(irq_vec_num) && $stable(irq_vec_addr))
        else $error("request dropped or changed");
    req_drop_a: assert property (irq_req && irq_ack |=> !irq_req)
        else $error("request kept after ack");
    block_req_a: assert property (irq_blocked |=> !$rose(irq_req))
        else $error("request during blocked window");
    arm_win_a: assert property (arm_w |=> vector_change_enable && irq_blocked)
        else $error("arm not taken");
    win_end_a: assert property (arm_w ##1 !general_irq_control.en [*4]
        |=> !vector_change_enable)
        else $error("change window too long");
    sel_commit_a: assert property (put_w && vector_change_enable |=>
        (vector_table_select == $past(general_irq_control.sel)
        && !vector_change_enable && irq_blocked) ##1 !irq_blocked)
        else $error("commit wrong");
    sel_closed_a: assert property (put_w && !vector_change_enable |=>
        $stable(vector_table_select))
        else $error("select changed without arm");
endmodule

bind rvp_vector_ctl rvp_vector_ctl_assertions #(.CE_WINDOW(CE_WINDOW)) u_chk (.*);

/* File: rvp_core_model.sv */
// behavioural core that takes vectors, promptly or after a delay
`timescale 1ns/1ps
`include "rvp_defs.svh"
module rvp_core_model (
    // clock and reset
    input wire logic                   clk_sys,
    input wire logic                   rstn,
    // vector request and answer
    input wire logic                   irq_req,
    input wire logic [`RVP_NUM_W-1:0]  irq_vec_num,
    input wire logic [`RVP_ADDR_W-1:0] irq_vec_addr,
    input wire logic [3:0]             ack_delay,
    output logic                       irq_ack,
    output logic [`RVP_NUM_W-1:0]      got_num,
    output logic [`RVP_ADDR_W-1:0]     got_addr
);
    logic [3:0] wait_q;
    // ack is a one-cycle pulse; vector is latched while the request stands
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            irq_ack <= 1'b0;
            wait_q <= 4'h0;
        end else if (irq_ack) begin
            irq_ack <= 1'b0;
        end else if (irq_req && wait_q >= ack_delay) begin
            irq_ack <= 1'b1;
            got_num <= irq_vec_num;
            got_addr <= irq_vec_addr;
            wait_q <= 4'h0;
        end else if (irq_req) begin
            wait_q <= wait_q + 4'h1;
        end
    end
endmodule

/* File: rvp_vector_ctl_tb.sv */
// self-checking bench for reset and interrupt vector placement
`timescale 1ns/1ps
`include "rvp_defs.svh"
module rvp_vector_ctl_tb
    import rvp_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic boot_reset_select_fuse = 1'b1;
    logic [11:0] boot_start_addr = 12'hC00;
    logic [17:0] irq_pending = '0;
    logic global_irq_enable = 1'b0;
    rvp_ctl_wr_t general_irq_control = '0;
    logic [3:0] ack_delay = 4'h0;
    logic irq_ack, reset_fetch, irq_req;
    logic vector_table_select, vector_change_enable, irq_blocked;
    logic [11:0] reset_addr, irq_vec_addr, got_addr;
    logic [4:0] irq_vec_num, got_num;
    int n_mismatch = 0;
    int samples_checked = 0;
    int cyc = 0;

    rvp_vector_ctl #(.N_SRC(18), .CE_WINDOW(3'h4)) u_rvp_vector_ctl (.*);
    rvp_core_model u_rvp_core_model (.*);

    always #2 clk_sys = ~clk_sys;

    task automatic end_of_test;
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // a hang counts as a mismatch
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_mismatch++;
            end_of_test;
        end
    end

    task automatic chk(input string what, input logic [11:0] exp, got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic do_reset(input logic f, input logic [11:0] b);
        @(posedge clk_sys) rstn <= 1'b0;
        boot_reset_select_fuse <= f;
        boot_start_addr <= b;
        repeat (16) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        chk("reset_fetch", 12'h001, 12'(reset_fetch));
        chk("reset_addr", f ? 12'h000 : b, reset_addr);
    endtask

    // waits for the core to take a vector, then the source withdraws
    task automatic collect(input int num, input logic [11:0] base);
        for (int n = 0; n < 40 && irq_ack !== 1'b1; n++) begin
            @(posedge clk_sys);
            #1;
        end
        @(posedge clk_sys) irq_pending <= '0;
        chk("vec_num", 12'(num), 12'(got_num));
        chk("vec_addr", base + 12'(num - 1), got_addr);
    endtask

    task automatic t_table(input logic [11:0] base);
        for (int i = 0; i < 18; i++) begin
            @(posedge clk_sys) irq_pending <= 18'h1 << i;
            global_irq_enable <= 1'b1;
            collect(i + 2, base);
        end
        @(posedge clk_sys) irq_pending <= 18'h20810;
        collect(6, base);
    endtask

    task automatic t_block(input logic [11:0] base);
        @(posedge clk_sys) general_irq_control <= '{1'b1, 1'b0, 1'b1};
        irq_pending <= 18'h1;
        global_irq_enable <= 1'b1;
        @(posedge clk_sys) general_irq_control <= '0;
        repeat (4) begin
            #1;
            chk("irq_req", 12'h000, 12'(irq_req));
            chk("change_en", 12'h001, 12'(vector_change_enable));
            chk("blocked", 12'h001, 12'(irq_blocked));
            @(posedge clk_sys);
        end
        collect(2, base);
        chk("select", 12'h000, 12'(vector_table_select));
    endtask

    task automatic t_switch(input logic s);
        @(posedge clk_sys) general_irq_control <= '{1'b1, s, 1'b0};
        @(posedge clk_sys) general_irq_control <= '{1'b1, 1'b0, 1'b1};
        #1;
        chk("closed_write", 12'(!s), 12'(vector_table_select));
        @(posedge clk_sys) general_irq_control <= '{1'b1, s, 1'b0};
        @(posedge clk_sys) general_irq_control <= '0;
        #1;
        chk("select", 12'(s), 12'(vector_table_select));
    endtask

    initial begin
        do_reset(1'b1, 12'hC00);
        t_table(12'h000);
        t_block(12'h000);
        t_switch(1'b1);
        @(posedge clk_sys) ack_delay <= 4'h3;
        t_table(12'hC00);
        t_switch(1'b0);
        do_reset(1'b0, 12'hC00);
        t_switch(1'b1);
        t_table(12'hC00);
        end_of_test;
    end
endmodule
